/* core/sfcap_dev.sv */
// Flash end: power-up hold, mode select and command address framing
//
// Functional notes
// - Three reserved bits, 12-bit page, 9-bit byte
// - 85,D2,E8 page and byte; D2,E8 four dummies
// - 84,87,D1,D3,D4,D6 byte only; D4,D6 one dummy
// - 86,88,89 use page, ignore byte field
// - Start in clock mode 3 after reset
// - Output high impedance after reset
// - Command starts only after select falls
// - Each select fall after power-on reset samples clock idle level
// - During power-on reset ignore all commands
// - Host waits 70 us before first select
// - Host waits 20 ms before program or erase
// - After power-up enter standby, not deep sleep
`timescale 1ns/1ps
`default_nettype none
module sfcap_dev
  import sfcap_pkg::*;
(
  input  wire logic                       i_ref_clk,
  input  wire logic                       i_rst_n,
  input  wire logic                       i_por_n,
  sfcap_if.dev                            link,
  output var  logic                       o_cmd_valid,
  output var  logic [sfcap_pkg::OPC_W-1:0]  o_opcode,
  output var  logic [sfcap_pkg::PAGE_W-1:0] o_page_addr,
  output var  logic [sfcap_pkg::BYTE_W-1:0] o_byte_addr,
  output var  logic                       o_page_used,
  output var  logic                       o_byte_used,
  output var  logic                       o_mode3,
  output var  logic                       o_standby,
  output var  logic                       o_so_oe,
  output var  logic                       o_so_out
);
  import sfcap_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [1:0]    cs_sync;
  logic [1:0]    sck_sync;
  logic [1:0]    si_sync;
  logic [1:0]    por_sync;
  logic          cs_q;
  logic          sck_q;
  logic          armed;
  sfcap_state_t  state;
  logic [4:0]    bit_cnt;
  logic [3:0]    dummy_left;
  logic [ADDR_W-1:0] shreg;
  logic [OPC_W-1:0]  opc;
  logic          cs_fall;
  logic          cs_rise;
  logic          sck_rise;
  logic          por_ok;

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cs_sync  <= 2'b11;
      sck_sync <= 2'b11;
      si_sync  <= 2'b00;
      por_sync <= 2'b00;
    end else begin
      cs_sync  <= {cs_sync[0], link.cs_n};
      sck_sync <= {sck_sync[0], link.sck};
      si_sync  <= {si_sync[0], link.si};
      por_sync <= {por_sync[0], i_por_n};
    end
  end

  assign por_ok   = por_sync[1];
  assign cs_fall  = cs_q & ~cs_sync[1];
  assign cs_rise  = ~cs_q & cs_sync[1];
  assign sck_rise = ~sck_q & sck_sync[1] & ~cs_sync[1];

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cs_q  <= 1'b1;
      sck_q <= 1'b1;
    end else begin
      cs_q  <= cs_sync[1];
      sck_q <= sck_sync[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode select and power state
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_mode3 <= 1'b1;
    end else if (!por_ok) begin
      o_mode3 <= 1'b1;
    end else if (cs_fall) begin
      o_mode3 <= sck_sync[1];
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_standby <= 1'b0;
    end else begin
      o_standby <= por_ok;
    end
  end

  // Armed only by a select fall seen after power-on reset
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      armed <= 1'b0;
    end else if (!por_ok || cs_rise) begin
      armed <= 1'b0;
    end else if (cs_fall) begin
      armed <= 1'b1;
    end
  end

  // Output never driven by this framing logic
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_so_oe  <= 1'b0;
      o_so_out <= 1'b0;
    end else begin
      o_so_oe  <= 1'b0;
      o_so_out <= 1'b0;
    end
  end
  assign link.so_oe  = o_so_oe;
  assign link.so_out = o_so_out;

  ////////////////////////////////////////////////////////////////////////////
  // Command framing
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state      <= SFCAP_ST_OPC;
      bit_cnt    <= 5'h00;
      dummy_left <= 4'h0;
      shreg      <= '0;
      opc        <= OPC_NONE;
    end else if (!por_ok || cs_fall || cs_rise) begin
      state      <= SFCAP_ST_OPC;
      bit_cnt    <= 5'h00;
      dummy_left <= 4'h0;
    end else if (armed && sck_rise) begin
      shreg   <= {shreg[ADDR_W-2:0], si_sync[1]};
      bit_cnt <= bit_cnt + 5'h01;
      case (state)
        SFCAP_ST_OPC: begin
          if (bit_cnt == 5'(OPC_W - 1)) begin
            opc     <= {shreg[OPC_W-2:0], si_sync[1]};
            bit_cnt <= 5'h00;
            if (sfcap_fmt({shreg[OPC_W-2:0], si_sync[1]}) == SFCAP_FMT_NONE) begin
              state <= SFCAP_ST_SKIP;
            end else begin
              state <= SFCAP_ST_ADDR;
            end
          end
        end
        SFCAP_ST_ADDR: begin
          if (bit_cnt == 5'(ADDR_W - 1)) begin
            bit_cnt    <= 5'h00;
            dummy_left <= sfcap_dummy(opc);
            if (sfcap_dummy(opc) == DUMMY_NONE) begin
              state <= SFCAP_ST_DATA;
            end else begin
              state <= SFCAP_ST_DUMMY;
            end
          end
        end
        SFCAP_ST_DUMMY: begin
          if (bit_cnt == 5'(OPC_W - 1)) begin
            bit_cnt    <= 5'h00;
            dummy_left <= dummy_left - 4'h1;
            if (dummy_left == 4'h1) begin
              state <= SFCAP_ST_DATA;
            end
          end
        end
        SFCAP_ST_DATA: begin
          bit_cnt <= 5'h00;
        end
        SFCAP_ST_SKIP: begin
          bit_cnt <= 5'h00;
        end
        default: begin
          state <= SFCAP_ST_OPC;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoded command report, pulsed once dummies are done
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cmd_valid <= 1'b0;
      o_opcode    <= OPC_NONE;
      o_page_addr <= '0;
      o_byte_addr <= '0;
      o_page_used <= 1'b0;
      o_byte_used <= 1'b0;
    end else begin
      o_cmd_valid <= 1'b0;
      if (por_ok && armed && sck_rise && ((state == SFCAP_ST_ADDR
          && bit_cnt == 5'(ADDR_W - 1) && sfcap_dummy(opc) == DUMMY_NONE)
          || (state == SFCAP_ST_DUMMY && bit_cnt == 5'(OPC_W - 1)
          && dummy_left == 4'h1))) begin
        o_cmd_valid <= 1'b1;
        o_opcode    <= opc;
        if (state == SFCAP_ST_ADDR) begin
          o_page_addr <= shreg[PAGE_LSB-1 +: PAGE_W];
          o_byte_addr <= {shreg[BYTE_W-2:0], si_sync[1]};
        end else begin
          o_page_addr <= o_page_addr;
          o_byte_addr <= o_byte_addr;
        end
        o_page_used <= (sfcap_fmt(opc) != SFCAP_FMT_BYTE);
        o_byte_used <= (sfcap_fmt(opc) != SFCAP_FMT_PAGE);
      end else if (por_ok && armed && sck_rise && state == SFCAP_ST_ADDR
                   && bit_cnt == 5'(ADDR_W - 1)) begin
        o_page_addr <= shreg[PAGE_LSB-1 +: PAGE_W];
        o_byte_addr <= {shreg[BYTE_W-2:0], si_sync[1]};
      end
    end
  end
endmodule
`default_nettype wire

/* core/sfcap_host.sv */
// Host end: power-up waits, clock divider and command shifter
`timescale 1ns/1ps
`default_nettype none
module sfcap_host
  import sfcap_pkg::*;
#(
  parameter int unsigned VCSL_CYCLES = sfcap_pkg::VCSL_CYC,
  parameter int unsigned PUW_CYCLES  = sfcap_pkg::PUW_CYC,
  parameter int unsigned HALF_DIV    = 4
)(
  input  wire logic                         i_ref_clk,
  input  wire logic                         i_rst_n,
  input  wire logic                         i_start,
  input  wire logic                         i_is_write,
  input  wire logic                         i_mode3,
  input  wire logic [sfcap_pkg::OPC_W-1:0]  i_opcode,
  input  wire logic [sfcap_pkg::PAGE_W-1:0] i_page_addr,
  input  wire logic [sfcap_pkg::BYTE_W-1:0] i_byte_addr,
  sfcap_if.host                             link,
  output var  logic                         o_busy,
  output var  logic                         o_read_ok,
  output var  logic                         o_write_ok,
  output var  logic                         o_done
);
  import sfcap_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Power-up timers
  logic [31:0] up_cnt;
  logic [7:0]  div_cnt;
  logic        tick;
  logic        sck;
  logic        cs_n;
  logic        si;
  logic        idle_lvl;
  logic [6:0]  bits_left;
  logic [ADDR_W+OPC_W+4*OPC_W-1:0] sh;

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      up_cnt     <= 32'h0000_0000;
      o_read_ok  <= 1'b0;
      o_write_ok <= 1'b0;
    end else begin
      if (up_cnt != 32'(PUW_CYCLES)) begin
        up_cnt <= up_cnt + 32'h0000_0001;
      end
      o_read_ok  <= (up_cnt >= 32'(VCSL_CYCLES));
      o_write_ok <= (up_cnt >= 32'(PUW_CYCLES));
    end
  end

  // Clock divider enable
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_cnt <= 8'h00;
    end else if (div_cnt == 8'(HALF_DIV - 1)) begin
      div_cnt <= 8'h00;
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
  end
  assign tick = (div_cnt == 8'(HALF_DIV - 1));

  ////////////////////////////////////////////////////////////////////////////
  // Shifter: select fall, bits out on falling edge, MSB first
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cs_n      <= 1'b1;
      sck       <= 1'b1;
      si        <= 1'b0;
      idle_lvl  <= 1'b1;
      o_busy    <= 1'b0;
      o_done    <= 1'b0;
      bits_left <= 7'h00;
      sh        <= '0;
    end else begin
      o_done <= 1'b0;
      if (!o_busy) begin
        sck <= idle_lvl;
        if (i_start && o_read_ok && (!i_is_write || o_write_ok)) begin
          o_busy    <= 1'b1;
          idle_lvl  <= i_mode3;
          sck       <= i_mode3;
          sh        <= {i_opcode, 3'b000, i_page_addr, i_byte_addr,
                        {(4*OPC_W){1'b0}}};
          bits_left <= 7'(OPC_W + ADDR_W) + {3'b000, sfcap_dummy(i_opcode)} * 7'(OPC_W);
        end
      end else if (tick) begin
        if (cs_n) begin
          // Select falls with the clock still at its idle level
          cs_n <= 1'b0;
          if (!idle_lvl) begin
            si <= sh[$bits(sh)-1];
            sh <= {sh[$bits(sh)-2:0], 1'b0};
          end
        end else if (bits_left == 7'h00) begin
          cs_n   <= 1'b1;
          sck    <= idle_lvl;
          o_busy <= 1'b0;
          o_done <= 1'b1;
        end else if (!sck) begin
          sck       <= 1'b1;
          bits_left <= bits_left - 7'h01;
        end else begin
          sck <= 1'b0;
          si  <= sh[$bits(sh)-1];
          sh  <= {sh[$bits(sh)-2:0], 1'b0};
        end
      end
    end
  end

  assign link.cs_n = cs_n;
  assign link.sck  = sck;
  assign link.si   = si;
endmodule
`default_nettype wire

/* dv/serial_flash_cmd_addr_powerup_bench.sv */
// Bench joining the host and flash ends of the serial command link
`timescale 1ns/1ps
`default_nettype none
module serial_flash_cmd_addr_powerup_bench;
  import sfcap_pkg::*;
  typedef struct packed {
    logic [7:0]  opc;
    logic [11:0] page;
    logic [8:0]  byt;
    logic        pu;
    logic        bu;
    logic        m3;
  } sfcap_exp_t;
  logic        i_ref_clk;
  logic        i_rst_n;
  logic        i_por_n;
  logic        i_start;
  logic        i_is_write;
  logic        i_mode3;
  logic [7:0]  i_opcode;
  logic [11:0] i_page_addr;
  logic [8:0]  i_byte_addr;
  logic        busy, read_ok, write_ok, done;
  logic        valid [2], page_u [2], byte_u [2], mode3 [2], standby [2], so_oe [2], so_out [2];
  logic [7:0]  opc_o [2];
  logic [11:0] page_o [2];
  logic [8:0]  byte_o [2];
  int          failures;
  int          tests_run;
  integer      seed;
  sfcap_exp_t  exp_q [2][$];
  logic [7:0]  opc_tab [13] = '{8'h85, 8'hD2, 8'hE8, 8'h84, 8'h87, 8'hD1, 8'hD3, 8'hD4,
                               8'hD6, 8'h86, 8'h88, 8'h89, 8'h9F};
  sfcap_if links [2] ();
  ////////////////////////////////////////////////////////////
  for (genvar g = 0; g < 2; g++) begin : g_dev
    sfcap_dev sfcap_dev_i (
      .i_ref_clk   (i_ref_clk),
      .i_rst_n     (i_rst_n),
      .i_por_n     (i_por_n),
      .link        (links[g]),
      .o_cmd_valid (valid[g]),
      .o_opcode    (opc_o[g]),
      .o_page_addr (page_o[g]),
      .o_byte_addr (byte_o[g]),
      .o_page_used (page_u[g]),
      .o_byte_used (byte_u[g]),
      .o_mode3     (mode3[g]),
      .o_standby   (standby[g]),
      .o_so_oe     (so_oe[g]),
      .o_so_out    (so_out[g])
    );
  end
  sfcap_host #(.VCSL_CYCLES(20), .PUW_CYCLES(60), .HALF_DIV(4)) sfcap_host_i (
    .i_ref_clk   (i_ref_clk),
    .i_rst_n     (i_rst_n),
    .i_start     (i_start),
    .i_is_write  (i_is_write),
    .i_mode3     (i_mode3),
    .i_opcode    (i_opcode),
    .i_page_addr (i_page_addr),
    .i_byte_addr (i_byte_addr),
    .link        (links[0]),
    .o_busy      (busy),
    .o_read_ok   (read_ok),
    .o_write_ok  (write_ok),
    .o_done      (done)
  );
  sfcap_asserts #(.VCSL_CYCLES(20)) sfcap_asserts_i (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .cs_n      (links[0].cs_n),
    .sck       (links[0].sck),
    .si        (links[0].si),
    .so_out    (links[0].so_out),
    .so_oe     (links[0].so_oe),
    .so        (links[0].so)
  );
  ////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge i_ref_clk);
    #2;
  endtask
  task automatic fail(input string m);
    failures++;
    $display("Error %0t: %s", $time, m);
  endtask
  task automatic check_bit(input logic v, input logic e, input string m);
    tests_run++;
    if (v !== e) fail(m);
  endtask
  task automatic check_cmd(input int k, input sfcap_exp_t e);
    tests_run++;
    if (opc_o[k] !== e.opc || page_u[k] !== e.pu || byte_u[k] !== e.bu || mode3[k] !== e.m3
        || (e.pu && page_o[k] !== e.page) || (e.bu && byte_o[k] !== e.byt)) fail("command fields");
  endtask
  task automatic print_verdict();
    if (failures == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Host frame with random address fields
  task automatic send(input int idx, input logic m3);
    sfcap_exp_t e;
    int         n;
    i_opcode = opc_tab[idx];
    i_mode3 = m3;
    i_page_addr = 12'($random(seed));
    i_byte_addr = 9'($random(seed));
    i_is_write = 1'($random(seed)) & write_ok;
    e = '{opc_tab[idx], i_page_addr, i_byte_addr, idx < 3 || idx > 8, idx < 9, m3};
    if (idx < 12 && i_por_n) exp_q[0].push_back(e);
    i_start = 1'b1;
    for (n = 0; n < 50 && busy !== 1'b1; n++) tick(1);
    i_start = 1'b0;
    for (n = 0; n < 2000 && done !== 1'b1; n++) tick(1);
    if (n == 2000) fail("frame hung");
    tick(6);
  endtask
  // Bench-made frame bits on the second link, clock idle low
  task automatic bang(input logic [31:0] v, input int n);
    for (int b = n - 1; b >= 0; b--) begin
      links[1].si = v[b];
      tick(4);
      links[1].sck = 1'b1;
      tick(4);
      links[1].sck = 1'b0;
    end
    links[1].si = ~v[0];
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    i_ref_clk = 1'b0;
    forever #12.5 i_ref_clk = ~i_ref_clk;
  end
  always @(negedge i_ref_clk) begin
    for (int k = 0; k < 2; k++) begin
      if (i_rst_n === 1'b1 && valid[k] === 1'b1) begin
        if (exp_q[k].size() == 0) fail("unexpected command");
        else check_cmd(k, exp_q[k].pop_front());
      end
    end
  end
  initial begin
    #1_000_000;
    fail("watchdog expired");
    print_verdict();
  end
  initial begin
    seed = 32'h0000_fae8;
    i_rst_n = 1'b0;
    i_por_n = 1'b0;
    i_start = 1'b0;
    i_is_write = 1'b0;
    i_mode3 = 1'b1;
    i_opcode = 8'h00;
    i_page_addr = 12'h000;
    i_byte_addr = 9'h000;
    links[1].cs_n = 1'b0;
    links[1].sck = 1'b0;
    links[1].si = 1'b0;
    tick(2);
    i_rst_n = 1'b1;
    tick(1);
    check_bit(mode3[0], 1'b1, "mode after reset");
    check_bit(so_oe[1], 1'b0, "output enabled");
    check_bit(read_ok, 1'b0, "read allowed early");
    i_start = 1'b1;
    tick(3);
    check_bit(busy, 1'b0, "select before read delay");
    i_start = 1'b0;
    tick(21);
    check_bit(read_ok, 1'b1, "read never allowed");
    check_bit(write_ok, 1'b0, "write allowed early");
    i_is_write = 1'b1;
    i_start = 1'b1;
    tick(3);
    check_bit(busy, 1'b0, "write before write delay");
    i_start = 1'b0;
    i_is_write = 1'b0;
    tick(1);
    send(0, 1'b1);
    check_bit(standby[0], 1'b0, "standby under reset");
    i_por_n = 1'b1;
    tick(6);
    check_bit(standby[0], 1'b1, "no standby");
    check_bit(write_ok, 1'b1, "write never allowed");
    for (int i = 0; i < 13; i++) send(i, i[0]);
    bang(32'h8500_1234, 32);
    links[1].cs_n = 1'b1;
    tick(4);
    links[1].cs_n = 1'b0;
    tick(4);
    bang(32'h0000_8500, 16);
    links[1].cs_n = 1'b1;
    tick(4);
    exp_q[1].push_back(sfcap_exp_t'{8'h84, 12'h000, 9'h15a, 1'b0, 1'b1, 1'b0});
    links[1].cs_n = 1'b0;
    tick(4);
    bang({8'h84, 3'b000, 12'hfff, 9'h15a}, 32);
    tick(4);
    links[1].cs_n = 1'b1;
    tick(20);
    check_bit(exp_q[0].size() == 0 && exp_q[1].size() == 0, 1'b1, "command missing");
    print_verdict();
  end
endmodule
`default_nettype wire

/* dv/sfcap_asserts.sv */
// Concurrent checks on the serial command link between the two ends
`timescale 1ns/1ps
`default_nettype none
module sfcap_asserts #(
  parameter int unsigned VCSL_CYCLES = 2800
)(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic so_out,
  input wire logic so_oe,
  input wire logic so
);
  logic        sck_q;
  logic [7:0]  bits;
  logic [31:0] since_rst;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  ////////////////////////////////////////////////////////////
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) sck_q <= 1'b1;
    else sck_q <= sck;
  end
  // Rising link clock edges within one frame
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) bits <= 8'h00;
    else if (cs_n) bits <= 8'h00;
    else if (sck && !sck_q) bits <= bits + 8'h01;
  end
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) since_rst <= 32'h0000_0000;
    else if (since_rst != 32'hffff_ffff) since_rst <= since_rst + 32'h0000_0001;
  end
  ////////////////////////////////////////////////////////////
  a_so_released: assert property (!so_oe && !so_out && so)
    else $error("serial output driven");
  a_reset_idle: assert property ($rose(i_rst_n) |-> cs_n && sck)
    else $error("link not idle after reset");
  a_select_wait: assert property (!cs_n |-> since_rst >= VCSL_CYCLES)
    else $error("select too early after reset");
  a_frame_length: assert property ($rose(cs_n) |-> bits inside {8'h08, 8'h20, 8'h28, 8'h40})
    else $error("frame bit count wrong");
  a_frame_bound: assert property ($fell(cs_n) |-> ##[1:700] cs_n)
    else $error("frame never closed");
  a_cs_gap: assert property ($rose(cs_n) |-> cs_n [*3])
    else $error("select gap too short");
  a_sck_half: assert property (!cs_n && $rose(sck) |-> sck [*3])
    else $error("link clock high too short");
  a_si_settled: assert property (!cs_n && !$past(cs_n) && $changed(si) |-> !sck)
    else $error("data moved while clock high");
endmodule
`default_nettype wire

/* pkg/sfcap_if.sv */
// Serial link between the host controller and the flash command end
`timescale 1ns/1ps
`default_nettype none
interface sfcap_if;
  logic cs_n;
  logic sck;
  logic si;
  logic so_out;
  logic so_oe;
  logic so;

  assign so = so_oe ? so_out : 1'b1;

  modport dev (
    input  cs_n,
    input  sck,
    input  si,
    output so_out,
    output so_oe
  );

  modport host (
    output cs_n,
    output sck,
    output si,
    input  so
  );
endinterface
`default_nettype wire

/* pkg/sfcap_pkg.sv */
// Shared constants and types for the serial flash command framing ends
package sfcap_pkg;
  localparam int unsigned OPC_W         = 8;
  localparam int unsigned ADDR_W        = 24;
  localparam int unsigned PAGE_W        = 12;
  localparam int unsigned BYTE_W        = 9;
  localparam int unsigned PAGE_LSB      = 9;
  localparam int unsigned BYTE_LSB      = 0;
  localparam int unsigned ADDR_BYTES    = 3;
  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned VCSL_US       = 70;
  localparam int unsigned PUW_MS        = 20;
  localparam int unsigned VCSL_CYC      = (VCSL_US * (CLK_HZ / 1_000_000) + 0);
  localparam int unsigned PUW_CYC       = (PUW_MS * (CLK_HZ / 1_000));
  localparam logic [3:0]  DUMMY_NONE    = 4'h0;
  localparam logic [3:0]  DUMMY_ONE     = 4'h1;
  localparam logic [3:0]  DUMMY_FOUR    = 4'h4;
  localparam logic [7:0]  OPC_85        = 8'h85;
  localparam logic [7:0]  OPC_D2        = 8'hD2;
  localparam logic [7:0]  OPC_E8        = 8'hE8;
  localparam logic [7:0]  OPC_84        = 8'h84;
  localparam logic [7:0]  OPC_87        = 8'h87;
  localparam logic [7:0]  OPC_D1        = 8'hD1;
  localparam logic [7:0]  OPC_D3        = 8'hD3;
  localparam logic [7:0]  OPC_D4        = 8'hD4;
  localparam logic [7:0]  OPC_D6        = 8'hD6;
  localparam logic [7:0]  OPC_86        = 8'h86;
  localparam logic [7:0]  OPC_88        = 8'h88;
  localparam logic [7:0]  OPC_89        = 8'h89;
  localparam logic [7:0]  OPC_NONE      = 8'h00;

  typedef enum logic [1:0] {
    SFCAP_FMT_NONE = 2'b00,
    SFCAP_FMT_BOTH = 2'b01,
    SFCAP_FMT_BYTE = 2'b10,
    SFCAP_FMT_PAGE = 2'b11
  } sfcap_fmt_t;

  typedef enum logic [2:0] {
    SFCAP_ST_OPC   = 3'b000,
    SFCAP_ST_ADDR  = 3'b001,
    SFCAP_ST_DUMMY = 3'b010,
    SFCAP_ST_DATA  = 3'b011,
    SFCAP_ST_SKIP  = 3'b100
  } sfcap_state_t;

  // Address format of one opcode
  function automatic sfcap_fmt_t sfcap_fmt(input logic [7:0] opc);
    case (opc)
      OPC_85, OPC_D2, OPC_E8:                         sfcap_fmt = SFCAP_FMT_BOTH;
      OPC_84, OPC_87, OPC_D1, OPC_D3, OPC_D4, OPC_D6: sfcap_fmt = SFCAP_FMT_BYTE;
      OPC_86, OPC_88, OPC_89:                         sfcap_fmt = SFCAP_FMT_PAGE;
      default:                                        sfcap_fmt = SFCAP_FMT_NONE;
    endcase
  endfunction

  // Trailing don't-care bytes of one opcode
  function automatic logic [3:0] sfcap_dummy(input logic [7:0] opc);
    case (opc)
      OPC_D2, OPC_E8: sfcap_dummy = DUMMY_FOUR;
      OPC_D4, OPC_D6: sfcap_dummy = DUMMY_ONE;
      default:        sfcap_dummy = DUMMY_NONE;
    endcase
  endfunction
endpackage
